// *** rtl/osd_cfg_pkg.sv ***
// Constants for the on-screen-display configuration, PWM D/A and colour block.
// Assumes registers are reached as word slots whose index is the byte address / 4.
// How it works
// - Double width halves pixel rate; reset zero
// - Horizontal sync polarity bit selects active level
// - Vertical sync polarity bit selects active level
// - Rate field divides crystal by 8/4/2/1
// - D/A period spans 256 PWM clocks
// - Window shadow colour field, reset black
// - Character edge colour field, reset black
// - Colour-font bit remaps codes 240..255
// - Per-window shadow width 2/4/6/8 pixels
// - Per-window shadow height 2/4/6/8 lines
// - Encoder merges window, edge, dots, colour
// - Eight open-drain outputs, 8-bit duty each
// - Channel rising edges staggered half PWM clock
// - Upper nibble A enters test mode
// - Shared pin outputs flyback-synced 50/50 clock
// - Shadow enable turns on window shadow
package osd_cfg_pkg;
    // Register indices (byte address = index * 4)
    localparam logic [5:0] IDX_CTRL   = 6'h12;
    localparam logic [5:0] IDX_SHCOL  = 6'h13;
    localparam logic [5:0] IDX_FONT   = 6'h14;
    localparam logic [5:0] IDX_SHW    = 6'h15;
    localparam logic [5:0] IDX_SHH    = 6'h16;
    localparam logic [5:0] IDX_SHEN   = 6'h18;
    localparam logic [5:0] IDX_STAT   = 6'h19;
    localparam logic [5:0] IDX_TEST   = 6'h1f;
    localparam logic [5:0] IDX_DUTY0  = 6'h20;
    // Control byte fields
    localparam int CTRL_DAC_CLOCK_OUT = 5;
    localparam int CTRL_DWE   = 4;
    localparam int CTRL_HSP   = 3;
    localparam int CTRL_VSP   = 2;
    localparam int CTRL_RATE  = 0;
    // Shadow colour fields (low bit of each 3-bit group)
    localparam int SHCOL_WIN  = 4;
    localparam int SHCOL_CHR  = 0;
    // Reset values
    localparam logic [7:0] CTRL_RST  = 8'h40;
    localparam logic [7:0] SHCOL_RST = 8'h00;
    localparam logic [7:0] FONT_RST  = 8'h00;
    localparam logic [7:0] SHW_RST   = 8'h00;
    localparam logic [7:0] SHH_RST   = 8'h00;
    localparam logic [7:0] TEST_RST  = 8'h00;
    localparam logic [7:0] DUTY_RST  = 8'h00;
    localparam logic [3:0] SHEN_RST  = 4'h0;
    // Test entry nibble
    localparam logic [3:0] TEST_KEY  = 4'ha;
    // Crystal edges per half PWM clock at rate code 00
    localparam logic [3:0] HALF_DIV_MAX = 4'h8;
    // Colour font code range base
    localparam logic [7:0] COLOUR_FONT_SELECT_BASE = 8'hf0;
    // AHB transfer type bit marking an active transfer
    localparam int HTRANS_ACT = 1;
endpackage

// *** rtl/pwm_dac_bank.sv ***
// Eight PWM D/A channels driven by half-period steps of the PWM clock.
// Assumes half_step pulses once per half PWM clock period, on hclk.
`timescale 1ns/1ps
module pwm_dac_bank
    import osd_cfg_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  ce,
    // Timing
    input  wire logic                  half_step,
    // Duty values, channel k at bits 8k+7..8k
    input  wire logic [8*CHANNELS-1:0] dac_duty_regs,
    // Open-drain pins
    output logic [CHANNELS-1:0]        pwm_o,
    output logic [CHANNELS-1:0]        pwm_oe,
    // Shared count
    output logic [7:0]                 pwm_count
);
    // Elaboration guard on the channel count
    if (CHANNELS < 1 || CHANNELS > 256) begin : g_bad_channels
        $error("CHANNELS out of range");
    end

    logic [8:0]          half_cnt;       // Half-step count, upper 8 bits are PWM count
    logic [8:0]          next_half_cnt;
    logic [CHANNELS-1:0] drive_low;      // Registered low drive per channel
    logic [CHANNELS-1:0] next_drive_low;

    // Free-running count in half PWM clock steps
    always_comb begin
        next_half_cnt = half_cnt;
        if (half_step) begin
            next_half_cnt = half_cnt + 9'h001;
        end
    end

    // Per channel compare against its own shifted phase
    for (genvar k = 0; k < CHANNELS; k++) begin : g_ch
        logic [8:0] phase;               // Count delayed by k half steps
        assign phase = half_cnt - 9'(k);
        always_comb begin
            next_drive_low[k] = ~(phase[8:1] < dac_duty_regs[8*k +: 8]);
        end
    end

    // Register count and pin drive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_cnt  <= 9'h000;
            drive_low <= {CHANNELS{1'b1}};
        end else if (ce) begin
            half_cnt  <= next_half_cnt;
            drive_low <= next_drive_low;
        end
    end

    assign pwm_o     = '0;                // Open drain only ever pulls low
    assign pwm_oe    = drive_low;
    assign pwm_count = half_cnt[8:1];
endmodule

// *** rtl/colour_encoder.sv ***
// Merges window, shadow, edge and dot layers onto the three video outputs.
// Assumes layer inputs arrive aligned to the pixel enable on hclk.
`timescale 1ns/1ps
module colour_encoder
    import osd_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ce,
    input  wire logic       pix_en,
    // Layers
    input  wire logic       window_on,
    input  wire logic [2:0] window_rgb,
    input  wire logic       win_shadow_on,
    input  wire logic [2:0] win_shadow_rgb,
    input  wire logic       char_edge_on,
    input  wire logic [2:0] char_edge_rgb,
    input  wire logic       lum_dot,
    input  wire logic [2:0] char_rgb,
    input  wire logic       colour_font_on,
    input  wire logic [2:0] font_dots_rgb,
    // Video
    output logic            red_video_out,
    output logic            green_video_out,
    output logic            blue_video_out
);
    logic [2:0] rgb;       // Registered colour
    logic [2:0] next_rgb;

    // Layer priority: dots, edge, shadow, window, black
    always_comb begin
        next_rgb = rgb;
        if (pix_en) begin
            if (colour_font_on && (font_dots_rgb != 3'h0)) begin
                next_rgb = font_dots_rgb;
            end else if (lum_dot && !colour_font_on) begin
                next_rgb = char_rgb;
            end else if (char_edge_on) begin
                next_rgb = char_edge_rgb;
            end else if (win_shadow_on) begin
                next_rgb = win_shadow_rgb;
            end else if (window_on) begin
                next_rgb = window_rgb;
            end else begin
                next_rgb = 3'h0;
            end
        end
    end

    // Output register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rgb <= 3'h0;
        end else if (ce) begin
            rgb <= next_rgb;
        end
    end

    assign red_video_out   = rgb[2];
    assign green_video_out = rgb[1];
    assign blue_video_out  = rgb[0];
endmodule

// *** rtl/osd_config_pwm_dac.sv ***
// Configuration register bank with PWM D/A, sync conditioning and colour encoder.
// Assumes an AHB-Lite master on hclk and asynchronous pins for crystal and syncs.
`timescale 1ns/1ps
module osd_config_pwm_dac
    import osd_cfg_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock, reset, enable
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                ce,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    // Asynchronous pins
    input  wire logic                crystal_clock_in,
    input  wire logic                hsync_in,
    input  wire logic                vsync_in,
    input  wire logic                horizontal_flyback_in,
    // Conditioned syncs
    output logic                     hsync_active,
    output logic                     vsync_active,
    // Half-tone / PWM clock shared pin
    input  wire logic                half_tone_in,
    output logic                     half_tone_out,
    output logic                     dac_clock_out,
    // PWM open-drain pins
    output logic [CHANNELS-1:0]      pwm_o,
    output logic [CHANNELS-1:0]      pwm_oe,
    // Pixel pacing and font map
    output logic                     pixel_enable,
    input  wire logic [7:0]          char_code,
    output logic                     font_colour_map,
    // Window shadow geometry, four bits per window
    output logic [15:0]              shadow_width_px,
    output logic [15:0]              shadow_height_ln,
    input  wire logic [3:0]          win_shadow_zone,
    // Colour layers
    input  wire logic                window_on,
    input  wire logic [2:0]          window_rgb,
    input  wire logic                char_edge_on,
    input  wire logic                lum_dot,
    input  wire logic [2:0]          char_rgb,
    input  wire logic [2:0]          font_dots_rgb,
    output logic                     red_video_out,
    output logic                     green_video_out,
    output logic                     blue_video_out,
    // Test
    output logic                     test_mode
);
    if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
        $error("CHANNELS out of range");
    end

    // ---------------- Pin conditioning ----------------
    localparam int NPIN = 4;
    logic [NPIN-1:0] pin_raw;     // Raw pins
    logic [NPIN-1:0] pin_s1;      // First stage
    logic [NPIN-1:0] pin_s2;      // Second stage
    logic [NPIN-1:0] pin_s3;      // Third stage
    logic [NPIN-1:0] pin_lvl;     // Accepted level
    logic [NPIN-1:0] next_pin_lvl;

    assign pin_raw = {horizontal_flyback_in, vsync_in, hsync_in, crystal_clock_in};

    // Accept a level once the second and third stages agree
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
        always_comb begin
            next_pin_lvl[p] = (pin_s2[p] == pin_s3[p]) ? pin_s3[p] : pin_lvl[p];
        end
    end

    // Synchroniser stages
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1  <= '0;
            pin_s2  <= '0;
            pin_s3  <= '0;
            pin_lvl <= '0;
        end else if (ce) begin
            pin_s1  <= pin_raw;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_lvl <= next_pin_lvl;
        end
    end

    logic xtal_edge;     // Either crystal edge
    logic flyback_rise;  // Flyback start
    assign xtal_edge    = next_pin_lvl[0] ^ pin_lvl[0];
    assign flyback_rise = next_pin_lvl[3] & ~pin_lvl[3];

    // ---------------- Register file ----------------
    logic [7:0]            ctrl;          // Rate, polarities, width, pin option
    logic [7:0]            shadow_colour_select;
    logic [7:0]            colour_font_enable;
    logic [7:0]            window_shadow_width;
    logic [7:0]            window_shadow_height;
    logic [7:0]            test_mode_byte;
    logic [3:0]            window_shadow_enable;
    logic [8*CHANNELS-1:0] dac_duty_regs;
    logic [7:0]            next_ctrl;
    logic [7:0]            next_shcol;
    logic [7:0]            next_font;
    logic [7:0]            next_shw;
    logic [7:0]            next_shh;
    logic [7:0]            next_test;
    logic [3:0]            next_shen;
    logic [8*CHANNELS-1:0] next_duty;
    logic                  wr_pend;       // Write data phase pending
    logic                  next_wr_pend;
    logic [5:0]            wr_idx;        // Index of pending write
    logic [5:0]            next_wr_idx;
    logic [31:0]           rd_data;       // Registered read data
    logic [31:0]           next_rd_data;
    logic                  take;          // Address phase accepted
    logic [5:0]            a_idx;         // Address phase index
    logic [7:0]            wbyte;         // Write byte
    logic [7:0]            pwm_count;     // Shared PWM count

    assign take  = hsel & htrans[HTRANS_ACT] & hready;
    assign a_idx = haddr[7:2];
    assign wbyte = hwdata[7:0];

    // Address phase capture and read mux
    always_comb begin
        next_wr_pend = 1'b0;
        next_wr_idx  = wr_idx;
        next_rd_data = rd_data;
        if (take) begin
            next_wr_pend = hwrite;
            next_wr_idx  = a_idx;
            next_rd_data = 32'h0000_0000;
            if (!hwrite) begin
                unique case (a_idx)
                    IDX_CTRL:  next_rd_data[7:0] = ctrl;
                    IDX_SHCOL: next_rd_data[7:0] = shadow_colour_select;
                    IDX_FONT:  next_rd_data[7:0] = colour_font_enable;
                    IDX_SHW:   next_rd_data[7:0] = window_shadow_width;
                    IDX_SHH:   next_rd_data[7:0] = window_shadow_height;
                    IDX_SHEN:  next_rd_data[3:0] = window_shadow_enable;
                    IDX_STAT:  next_rd_data[15:0] = {pwm_count, 4'h0, dac_clock_out,
                                                     vsync_active, hsync_active, test_mode};
                    default: begin
                        for (int c = 0; c < CHANNELS; c++) begin
                            if (a_idx == IDX_DUTY0 + 6'(c)) begin
                                next_rd_data[7:0] = dac_duty_regs[8*c +: 8];
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Data phase write
    always_comb begin
        next_ctrl  = ctrl;
        next_shcol = shadow_colour_select;
        next_font  = colour_font_enable;
        next_shw   = window_shadow_width;
        next_shh   = window_shadow_height;
        next_test  = test_mode_byte;
        next_shen  = window_shadow_enable;
        next_duty  = dac_duty_regs;
        if (wr_pend) begin
            unique case (wr_idx)
                IDX_CTRL:  next_ctrl  = wbyte;
                IDX_SHCOL: next_shcol = wbyte & 8'h77;
                IDX_FONT:  next_font  = wbyte & 8'h01;
                IDX_SHW:   next_shw   = wbyte;
                IDX_SHH:   next_shh   = wbyte;
                IDX_SHEN:  next_shen  = wbyte[3:0];
                IDX_TEST:  next_test  = wbyte;
                default: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        if (wr_idx == IDX_DUTY0 + 6'(c)) begin
                            next_duty[8*c +: 8] = wbyte;
                        end
                    end
                end
            endcase
        end
    end

    // Register storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl                 <= CTRL_RST;
            shadow_colour_select <= SHCOL_RST;
            colour_font_enable   <= FONT_RST;
            window_shadow_width  <= SHW_RST;
            window_shadow_height <= SHH_RST;
            test_mode_byte       <= TEST_RST;
            window_shadow_enable <= SHEN_RST;
            dac_duty_regs        <= {CHANNELS{DUTY_RST}};
            wr_pend              <= 1'b0;
            wr_idx               <= 6'h00;
            rd_data              <= 32'h0000_0000;
        end else if (ce) begin
            ctrl                 <= next_ctrl;
            shadow_colour_select <= next_shcol;
            colour_font_enable   <= next_font;
            window_shadow_width  <= next_shw;
            window_shadow_height <= next_shh;
            test_mode_byte       <= next_test;
            window_shadow_enable <= next_shen;
            dac_duty_regs        <= next_duty;
            wr_pend              <= next_wr_pend;
            wr_idx               <= next_wr_idx;
            rd_data              <= next_rd_data;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rd_data;

    // ---------------- Decoded configuration ----------------
    assign hsync_active = ~(pin_lvl[1] ^ ctrl[CTRL_HSP]);
    assign vsync_active = ~(pin_lvl[2] ^ ctrl[CTRL_VSP]);
    assign test_mode    = (test_mode_byte[7:4] == TEST_KEY);
    assign font_colour_map = colour_font_enable[0] && (char_code >= COLOUR_FONT_SELECT_BASE);

    // Shadow size is 2 * (code + 1) when enabled, else zero
    for (genvar w = 0; w < 4; w++) begin : g_win
        assign shadow_width_px[4*w +: 4] = window_shadow_enable[w] ?
            {1'b0, window_shadow_width[2*w +: 2], 1'b0} + 4'h2 : 4'h0;
        assign shadow_height_ln[4*w +: 4] = window_shadow_enable[w] ?
            {1'b0, window_shadow_height[2*w +: 2], 1'b0} + 4'h2 : 4'h0;
    end

    // ---------------- PWM clock divider ----------------
    logic [3:0] half_div;    // Crystal edges per half PWM clock
    logic [3:0] div_cnt;     // Edge count within half period
    logic [3:0] next_div_cnt;
    logic       pwm_clk;     // PWM clock level
    logic       next_pwm_clk;
    logic       half_step;   // Half PWM period boundary

    assign half_div  = HALF_DIV_MAX >> ctrl[CTRL_RATE +: 2];
    assign half_step = xtal_edge && (div_cnt + 4'h1 >= half_div) && !flyback_rise;

    // Divider steps on crystal edges, realigned at flyback
    always_comb begin
        next_div_cnt = div_cnt;
        next_pwm_clk = pwm_clk;
        if (flyback_rise) begin
            next_div_cnt = 4'h0;
            next_pwm_clk = 1'b0;
        end else if (half_step) begin
            next_div_cnt = 4'h0;
            next_pwm_clk = ~pwm_clk;
        end else if (xtal_edge) begin
            next_div_cnt = div_cnt + 4'h1;
        end
    end

    // Divider state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 4'h0;
            pwm_clk <= 1'b0;
        end else if (ce) begin
            div_cnt <= next_div_cnt;
            pwm_clk <= next_pwm_clk;
        end
    end

    // ---------------- Shared pin and pixel pacing ----------------
    logic pin_out;       // Shared pin level
    logic next_pin_out;
    logic pix_phase;     // Double-width half-rate phase
    logic next_pix_phase;

    // Pin option select and half-rate toggle
    always_comb begin
        next_pin_out   = ctrl[CTRL_DAC_CLOCK_OUT] ? pwm_clk : half_tone_in;
        next_pix_phase = ~pix_phase;
        if (!ctrl[CTRL_DWE] || flyback_rise) begin
            next_pix_phase = 1'b1;
        end
    end

    // Pin and phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out   <= 1'b0;
            pix_phase <= 1'b1;
        end else if (ce) begin
            pin_out   <= next_pin_out;
            pix_phase <= next_pix_phase;
        end
    end

    assign half_tone_out = pin_out;
    assign dac_clock_out = pwm_clk;
    assign pixel_enable  = ~ctrl[CTRL_DWE] | pix_phase;

    // ---------------- Sub-blocks ----------------
    pwm_dac_bank #(
        .CHANNELS (CHANNELS)
    ) u_pwm (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .ce            (ce),
        .half_step     (half_step),
        .dac_duty_regs (dac_duty_regs),
        .pwm_o         (pwm_o),
        .pwm_oe        (pwm_oe),
        .pwm_count     (pwm_count)
    );

    colour_encoder u_enc (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .ce             (ce),
        .pix_en         (pixel_enable),
        .window_on      (window_on),
        .window_rgb     (window_rgb),
        .win_shadow_on  (|(win_shadow_zone & window_shadow_enable)),
        .win_shadow_rgb (shadow_colour_select[SHCOL_WIN +: 3]),
        .char_edge_on   (char_edge_on),
        .char_edge_rgb  (shadow_colour_select[SHCOL_CHR +: 3]),
        .lum_dot        (lum_dot),
        .char_rgb       (char_rgb),
        .colour_font_on (font_colour_map),
        .font_dots_rgb  (font_dots_rgb),
        .red_video_out  (red_video_out),
        .green_video_out(green_video_out),
        .blue_video_out (blue_video_out)
    );
endmodule

// *** dv/osd_cfg_asserts.sv ***
// Port checker for the configuration, PWM D/A and colour bank.
// Assumes one hclk domain and the asynchronous active-low hresetn.
`timescale 1ns/1ps
module osd_cfg_asserts
    import osd_cfg_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock, reset and bus
    input wire logic hclk, hresetn, hsel, hready, hreadyout, hresp,
    input wire logic [1:0] htrans,
    input wire logic [31:0] hrdata,
    // Watched outputs and the inputs they depend on
    input wire logic pixel_enable, font_colour_map, test_mode,
    input wire logic [7:0] char_code,
    input wire logic [15:0] shadow_width_px, shadow_height_ln,
    input wire logic [CHANNELS-1:0] pwm_o, pwm_oe,
    // Clock enable and the registered state it freezes
    input wire logic ce, dac_clock_out
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Register bus never stalls and never errors
    chk_always_ready: assert property (hreadyout && !hresp)
        else $error("bus stalled or errored");
    chk_font_range: assert property (font_colour_map |-> char_code[7:4] == 4'hf)
        else $error("colour font outside top sixteen codes");
    chk_width_code: assert property (!shadow_width_px[0] && shadow_width_px[3:0] <= 4'h8)
        else $error("window shadow width not 0,2,4,6,8");
    chk_height_code: assert property (!shadow_height_ln[0] && shadow_height_ln[3:0] <= 4'h8)
        else $error("window shadow height not 0,2,4,6,8");
    chk_drain_only: assert property (pwm_o == '0)
        else $error("pwm pin driven high");
    chk_test_reset: assert property ($rose(hresetn) |-> !test_mode)
        else $error("test mode set out of reset");
    chk_half_rate: assert property (!pixel_enable |=> pixel_enable)
        else $error("pixel enable low two cycles");
    chk_read_hold: assert property (!$past(hsel && htrans[1] && hready) |-> $stable(hrdata))
        else $error("read data moved without a request");
    chk_ce_freeze: assert property (!ce |=> $stable({pwm_oe, dac_clock_out, hrdata}))
        else $error("state moved while clock enable low");
endmodule

bind osd_config_pwm_dac osd_cfg_asserts #(.CHANNELS(CHANNELS)) u_chk (.*);

// *** dv/xtal_flyback_model.sv ***
// Far-side sources: crystal oscillator and horizontal flyback pulses.
// Assumes the bank samples both pins on its own hclk.
`timescale 1ns/1ps
module xtal_flyback_model (
    output logic crystal_clock_in,
    output logic horizontal_flyback_in
);
    // Crystal runs from time zero, so no write ever meets an absent crystal
    initial crystal_clock_in = 1'b0;
    always #250 crystal_clock_in = ~crystal_clock_in;
    // Flyback about every 31.5 us, pulse 500 ns wide
    initial begin
        horizontal_flyback_in = 1'b0;
        forever begin
            #31000 horizontal_flyback_in = 1'b1;
            #500 horizontal_flyback_in = 1'b0;
        end
    end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench: AHB-Lite register traffic, syncs, shadows, font map, PWM.
// Assumes the crystal and flyback model and the bound port checker.
`timescale 1ns/1ps
module tb_top;
    import osd_cfg_pkg::*;
    logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, hsync_in = 0, vsync_in = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, r, hrdata;
    logic hready, hreadyout, hresp, crystal_clock_in, horizontal_flyback_in, half_tone_in;
    logic window_on, char_edge_on, lum_dot, pd;
    logic [2:0] window_rgb, char_rgb, font_dots_rgb;
    logic [3:0] win_shadow_zone;
    logic [7:0] char_code, w;
    logic [24:0] lay = 0, lay_q = 0;
    logic hsync_active, vsync_active, half_tone_out, dac_clock_out, pixel_enable;
    logic font_colour_map, red_video_out, green_video_out, blue_video_out, test_mode;
    logic [7:0] pwm_o, pwm_oe;
    logic [15:0] shadow_width_px, shadow_height_ln;
    int n_fail = 0, checked = 0, cyc = 0, n0, n1, n2, n3;
    assign hready = hreadyout;
    always #50 hclk = ~hclk;
    osd_config_pwm_dac DUT (.*);
    xtal_flyback_model u_far (.*);
    // Random layer and character stimulus every cycle; lay_q is what the bank last sampled
    assign {window_on, window_rgb, char_edge_on, lum_dot, char_rgb, font_dots_rgb,
            win_shadow_zone, half_tone_in, char_code} = lay;
    always @(posedge hclk) begin
        lay_q <= lay;
        lay   <= 25'($urandom);
    end
    // Hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    // Expected shadow size: code c gives 2c+2
    function automatic logic [15:0] sh(input logic [7:0] c);
        for (int k = 0; k < 4; k++) sh[4*k+:4] = 4'(2 * c[2*k+:2] + 2);
    endfunction
    // Expected colour with colour fonts on: font dots, dot, edge, window shadow, window
    function automatic logic [2:0] enc(input logic [24:0] v, input logic [3:0] en,
                                       input logic [7:0] sc);
        logic cf;
        cf = v[7:0] >= 8'hf0;
        if (cf && v[15:13] != 3'h0) enc = v[15:13];
        else if (v[19] && !cf) enc = v[18:16];
        else if (v[20]) enc = sc[2:0];
        else if (|(v[12:9] & en)) enc = sc[6:4];
        else if (v[24]) enc = v[23:21];
        else enc = 3'h0;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One single AHB-Lite transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        #1;
    endtask
    task automatic summarize();
        $display("n_fail=%0d checked=%0d", n_fail, checked);
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(41));
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        bus(0, 32'h48, 0); cmp(r, 32'h40);
        bus(0, 32'h4c, 0); cmp(r, 0);
        bus(0, 32'h50, 0); cmp(r, 0);
        bus(0, 32'h100, 0); cmp(r, 0);
        bus(1, 32'h7c, 32'ha5); cmp(test_mode, 1);
        bus(0, 32'h7c, 0); cmp(r, 0);
        bus(1, 32'h7c, 0); cmp(test_mode, 0);
        // Both sync polarities, every rate code
        for (int p = 0; p < 4; p++) begin
            bus(1, 32'h48, {26'h0, p[0], 1'b0, p[0], p[0], 2'(p)});
            hsync_in <= 1;
            repeat (6) @(posedge hclk);
            #1 cmp(hsync_active, p[0]);
            cmp(vsync_active, !p[0]);
            bus(0, 32'h48, 0); cmp(r[5:0], {p[0], 1'b0, p[0], p[0], 2'(p)});
        end
        // Shadow codes: every code once in width, random height
        w = 8'($urandom);
        bus(1, 32'h54, 32'h1b);
        bus(1, 32'h58, {24'h0, w});
        bus(1, 32'h60, 0); cmp(shadow_width_px, 0);
        bus(1, 32'h60, 32'hf); cmp(shadow_width_px, sh(8'h1b));
        cmp(shadow_height_ln, sh(w));
        bus(0, 32'h58, 0); cmp(r, {24'h0, w});
        bus(1, 32'h4c, {24'h0, w});
        bus(0, 32'h4c, 0); cmp(r, {24'h0, w & 8'h77});
        bus(1, 32'h50, 1);
        @(posedge hclk);
        repeat (40) @(negedge hclk) begin
            cmp(font_colour_map, char_code >= 8'hf0);
            cmp({red_video_out, green_video_out, blue_video_out}, enc(lay_q, 4'hf, w));
        end
        bus(1, 32'h50, 0); cmp(font_colour_map, 0);
        // Mid-run reset clears written registers, then a frozen stretch
        bus(1, 32'h7c, 32'ha0); cmp(test_mode, 1);
        hresetn <= 0;
        @(posedge hclk);
        hresetn <= 1;
        cmp(test_mode, 0);
        cmp(shadow_width_px, 0);
        bus(0, 32'h50, 0); cmp(r, 0);
        bus(0, 32'h48, 0); cmp(r, 32'h40);
        ce <= 0;
        repeat (20) @(posedge hclk);
        ce <= 1;
        // Duty 0 and 255 at fastest rate, double width on
        bus(1, 32'h48, 32'h13);
        bus(1, 32'h80, 0);
        bus(1, 32'h84, 32'hff);
        n0 = 0; n1 = 0; n2 = 0; n3 = 0; pd = dac_clock_out;
        repeat (1500) @(negedge hclk) begin
            n0 += !pwm_oe[0];
            n1 += !pwm_oe[1];
            n2 += !pixel_enable;
            n3 += dac_clock_out != pd;
            pd = dac_clock_out;
            cmp(half_tone_out, lay_q[8]);
        end
        cmp(n0, 0);
        cmp(n1 > 1400, 1);
        cmp(n2 > 600, 1);
        cmp(n3 > 580 && n3 < 620, 1);
        summarize();
    end
endmodule
